// File: hw/cpu_regs_pkg.sv
// Purpose: Shared constants and types for the CPU programmer register set
// Assumes: 32-bit Avalon-MM data, byte addresses, one aligned word per register
// Notes:   Register port is private to the core, not part of the memory map
`default_nettype none
package cpu_regs_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_WORK        = 8'h00;
  localparam logic [7:0]  OFF_INDEX       = 8'h04;
  localparam logic [7:0]  OFF_STACK       = 8'h08;
  localparam logic [7:0]  OFF_PC          = 8'h0C;
  localparam logic [7:0]  OFF_FLAGS       = 8'h10;
  localparam logic [7:0]  OFF_CMD         = 8'h14;
  localparam logic [7:0]  OFF_STATUS      = 8'h18;

  localparam logic [15:0] STACK_RESET     = 16'h00FF;
  localparam logic [7:0]  STACK_LOW_VALUE = 8'hFF;
  localparam logic [7:0]  INDEX_HI_RESET  = 8'h00;
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR     = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR     = 16'hFFFF;
  localparam logic [15:0] PC_STEP         = 16'h0001;
  localparam logic [7:0]  BYTE_ONE        = 8'h01;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [7:0]  POS_MAX         = 8'h7F;
  localparam logic [7:0]  NEG_MIN         = 8'h80;

  // Flag bit positions
  localparam int          FLAG_V          = 7;
  localparam int          FLAG_H          = 4;
  localparam int          FLAG_I          = 3;
  localparam int          FLAG_N          = 2;
  localparam int          FLAG_Z          = 1;
  localparam int          FLAG_C          = 0;
  localparam logic [7:0]  FLAGS_FIXED     = 8'h60;
  localparam logic [7:0]  FLAGS_RESET     = 8'h68;

  // Decimal adjust
  localparam logic [3:0]  BCD_DIGIT_MAX   = 4'h9;
  localparam logic [7:0]  BCD_BYTE_MAX    = 8'h99;
  localparam logic [3:0]  BCD_FIX         = 4'h6;

  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_FETCH     = 5'h01,
    OP_STACK_ADJ = 5'h02,
    OP_STACK_LOW = 5'h03,
    OP_X_CLR     = 5'h04,
    OP_X_INC     = 5'h05,
    OP_X_DEC     = 5'h06,
    OP_X_COM     = 5'h07,
    OP_X_NEG     = 5'h08,
    OP_X_ASL     = 5'h09,
    OP_X_LSR     = 5'h0A,
    OP_X_ROL     = 5'h0B,
    OP_X_ROR     = 5'h0C,
    OP_TAX       = 5'h0D,
    OP_TXA       = 5'h0E,
    OP_ALU_ADD   = 5'h0F,
    OP_ALU_RES   = 5'h10,
    OP_BCD_ADJ   = 5'h11,
    OP_MASK_CLR  = 5'h12,
    OP_MASK_SET  = 5'h13,
    OP_BOUNDARY  = 5'h14,
    OP_VEC_BYTE  = 5'h15
  } op_t;

  typedef enum logic [2:0] {
    ST_VEC_HI = 3'b001,
    ST_VEC_LO = 3'b010,
    ST_RUN    = 3'b100
  } vec_state_t;

  typedef struct packed {
    logic [2:0] pad0;
    op_t        op;
    logic [4:0] pad1;
    logic       v;
    logic       h;
    logic       c;
    logic [7:0] pad2;
    logic [7:0] operand;
  } cmd_t;

  typedef struct packed {
    logic [26:0] pad;
    logic [2:0]  vec_state;
    logic        inhibit;
    logic        irq_allowed;
  } status_t;

  typedef struct packed {
    logic gt;
    logic ge;
    logic le;
    logic lt;
  } signed_cond_t;
endpackage : cpu_regs_pkg
`default_nettype wire

// File: hw/cpu_regs.sv
// Purpose: Programmer register set of an 8-bit CPU core
// Assumes: Decoder and ALU drive this block over a core-private Avalon-MM port
// Notes:   Working register and low index byte keep their value over reset
`default_nettype none
module cpu_regs (
  input  wire  logic                                core_clk,
  input  wire  logic                                reset,
  input  wire  logic [cpu_regs_pkg::ADDR_W-1:0]     address,
  input  wire  logic                                read,
  input  wire  logic                                write,
  input  wire  logic [31:0]                         writedata,
  output var   logic [31:0]                         readdata,
  output var   logic                                waitrequest,
  output var   logic [7:0]                          work_r,
  output var   logic [7:0]                          index_hi_r,
  output var   logic [7:0]                          index_lo_r,
  output var   logic [15:0]                         stack_r,
  output var   logic [15:0]                         pc_r,
  output var   logic [7:0]                          flags_r,
  output var   logic                                irq_allowed_r,
  output var   cpu_regs_pkg::signed_cond_t          signed_cond_r,
  output var   logic [15:0]                         vector_addr_r
);

  cpu_regs_pkg::cmd_t         cmd;
  cpu_regs_pkg::vec_state_t   vec_state_r;
  cpu_regs_pkg::status_t      status;
  logic                       wr_fire;
  logic                       wr_work;
  logic                       wr_index;
  logic                       wr_stack;
  logic                       wr_pc;
  logic                       wr_flags;
  logic                       cmd_fire;
  logic [15:0]                imm_sx;
  logic                       a_load;
  logic [7:0]                 a_nxt;
  logic                       x_load;
  logic [7:0]                 x_nxt;
  logic [7:0]                 flags_nxt;
  logic                       upd_nz;
  logic                       nz_wide;
  logic [15:0]                nz_val;
  logic                       lo_fix;
  logic                       hi_fix;
  logic                       inhibit_r;
  logic                       inhibit_nxt;
  logic                       fetch_ok;

  assign cmd      = cpu_regs_pkg::cmd_t'(writedata);
  assign wr_fire  = write && !waitrequest;
  assign wr_work  = wr_fire && (address == cpu_regs_pkg::OFF_WORK);
  assign wr_index = wr_fire && (address == cpu_regs_pkg::OFF_INDEX);
  assign wr_stack = wr_fire && (address == cpu_regs_pkg::OFF_STACK);
  assign wr_pc    = wr_fire && (address == cpu_regs_pkg::OFF_PC);
  assign wr_flags = wr_fire && (address == cpu_regs_pkg::OFF_FLAGS);
  assign cmd_fire = wr_fire && (address == cpu_regs_pkg::OFF_CMD);
  assign imm_sx   = {{8{cmd.operand[7]}}, cmd.operand};
  assign fetch_ok = (vec_state_r == cpu_regs_pkg::ST_RUN);

  // Bus handshake: one wait cycle, answer registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= 32'h0000_0000;
      if (read) begin
        unique case (address)
          cpu_regs_pkg::OFF_WORK:   readdata <= {24'h00_0000, work_r};
          cpu_regs_pkg::OFF_INDEX:  readdata <= {16'h0000, index_hi_r, index_lo_r};
          cpu_regs_pkg::OFF_STACK:  readdata <= {16'h0000, stack_r};
          cpu_regs_pkg::OFF_PC:     readdata <= {16'h0000, pc_r};
          cpu_regs_pkg::OFF_FLAGS:  readdata <= {24'h00_0000, flags_r};
          cpu_regs_pkg::OFF_STATUS: readdata <= status;
          default:                  readdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    status             = '0;
    status.vec_state   = vec_state_r;
    status.inhibit     = inhibit_r;
    status.irq_allowed = irq_allowed_r;
  end

  // Data path next values and flag update
  always_comb begin
    a_load    = 1'b0;
    a_nxt     = work_r;
    x_load    = 1'b0;
    x_nxt     = index_lo_r;
    flags_nxt = flags_r;
    upd_nz    = 1'b0;
    nz_wide   = 1'b0;
    nz_val    = cpu_regs_pkg::WORD_ZERO;
    lo_fix    = flags_r[cpu_regs_pkg::FLAG_H] ||
                (work_r[3:0] > cpu_regs_pkg::BCD_DIGIT_MAX);
    hi_fix    = flags_r[cpu_regs_pkg::FLAG_C] || (work_r > cpu_regs_pkg::BCD_BYTE_MAX);
    if (wr_work) begin
      a_load                        = 1'b1;
      a_nxt                         = writedata[7:0];
      upd_nz                        = 1'b1;
      nz_val                        = {8'h00, writedata[7:0]};
      flags_nxt[cpu_regs_pkg::FLAG_V] = 1'b0;
    end else if (wr_index) begin
      upd_nz                        = 1'b1;
      nz_wide                       = 1'b1;
      nz_val                        = writedata[15:0];
      flags_nxt[cpu_regs_pkg::FLAG_V] = 1'b0;
    end else if (wr_flags) begin
      flags_nxt = writedata[7:0];
    end else if (cmd_fire) begin
      unique case (cmd.op)
        cpu_regs_pkg::OP_X_CLR: begin
          x_load = 1'b1;
          x_nxt  = cpu_regs_pkg::BYTE_ZERO;
          flags_nxt[cpu_regs_pkg::FLAG_V] = 1'b0;
        end
        cpu_regs_pkg::OP_X_INC: begin
          x_load = 1'b1;
          x_nxt  = index_lo_r + cpu_regs_pkg::BYTE_ONE;
          flags_nxt[cpu_regs_pkg::FLAG_V] = (index_lo_r == cpu_regs_pkg::POS_MAX);
        end
        cpu_regs_pkg::OP_X_DEC: begin
          x_load = 1'b1;
          x_nxt  = index_lo_r - cpu_regs_pkg::BYTE_ONE;
          flags_nxt[cpu_regs_pkg::FLAG_V] = (index_lo_r == cpu_regs_pkg::NEG_MIN);
        end
        cpu_regs_pkg::OP_X_COM: begin
          x_load = 1'b1;
          x_nxt  = ~index_lo_r;
          flags_nxt[cpu_regs_pkg::FLAG_V] = 1'b0;
          flags_nxt[cpu_regs_pkg::FLAG_C] = 1'b1;
        end
        cpu_regs_pkg::OP_X_NEG: begin
          x_load = 1'b1;
          x_nxt  = cpu_regs_pkg::BYTE_ZERO - index_lo_r;
          flags_nxt[cpu_regs_pkg::FLAG_V] = (index_lo_r == cpu_regs_pkg::NEG_MIN);
          flags_nxt[cpu_regs_pkg::FLAG_C] = (index_lo_r != cpu_regs_pkg::BYTE_ZERO);
        end
        cpu_regs_pkg::OP_X_ASL, cpu_regs_pkg::OP_X_ROL: begin
          x_load = 1'b1;
          x_nxt  = {index_lo_r[6:0],
                    (cmd.op == cpu_regs_pkg::OP_X_ROL) && flags_r[cpu_regs_pkg::FLAG_C]};
          flags_nxt[cpu_regs_pkg::FLAG_C] = index_lo_r[7];
          flags_nxt[cpu_regs_pkg::FLAG_V] = index_lo_r[6] ^ index_lo_r[7];
        end
        cpu_regs_pkg::OP_X_LSR, cpu_regs_pkg::OP_X_ROR: begin
          x_load = 1'b1;
          x_nxt  = {(cmd.op == cpu_regs_pkg::OP_X_ROR) && flags_r[cpu_regs_pkg::FLAG_C],
                    index_lo_r[7:1]};
          flags_nxt[cpu_regs_pkg::FLAG_C] = index_lo_r[0];
          flags_nxt[cpu_regs_pkg::FLAG_V] = index_lo_r[0] ^
            ((cmd.op == cpu_regs_pkg::OP_X_ROR) && flags_r[cpu_regs_pkg::FLAG_C]);
        end
        cpu_regs_pkg::OP_TAX: begin
          x_load = 1'b1;
          x_nxt  = work_r;
        end
        cpu_regs_pkg::OP_TXA: begin
          a_load = 1'b1;
          a_nxt  = index_lo_r;
        end
        cpu_regs_pkg::OP_ALU_ADD, cpu_regs_pkg::OP_ALU_RES: begin
          a_load = 1'b1;
          a_nxt  = cmd.operand;
          flags_nxt[cpu_regs_pkg::FLAG_V] = cmd.v;
          flags_nxt[cpu_regs_pkg::FLAG_C] = cmd.c;
          if (cmd.op == cpu_regs_pkg::OP_ALU_ADD) begin
            flags_nxt[cpu_regs_pkg::FLAG_H] = cmd.h;
          end
        end
        cpu_regs_pkg::OP_BCD_ADJ: begin
          a_load = 1'b1;
          a_nxt  = work_r + {hi_fix ? cpu_regs_pkg::BCD_FIX : 4'h0,
                             lo_fix ? cpu_regs_pkg::BCD_FIX : 4'h0};
          flags_nxt[cpu_regs_pkg::FLAG_C] = hi_fix;
        end
        cpu_regs_pkg::OP_MASK_CLR: flags_nxt[cpu_regs_pkg::FLAG_I] = 1'b0;
        cpu_regs_pkg::OP_MASK_SET: flags_nxt[cpu_regs_pkg::FLAG_I] = 1'b1;
        default: begin
        end
      endcase
      if (a_load) begin
        upd_nz = 1'b1;
        nz_val = {8'h00, a_nxt};
      end else if (x_load && (cmd.op != cpu_regs_pkg::OP_TAX)) begin
        upd_nz = 1'b1;
        nz_val = {8'h00, x_nxt};
      end
    end
    if (upd_nz) begin
      flags_nxt[cpu_regs_pkg::FLAG_N] = nz_wide ? nz_val[15] : nz_val[7];
      flags_nxt[cpu_regs_pkg::FLAG_Z] = nz_wide ? (nz_val == cpu_regs_pkg::WORD_ZERO) :
                                        (nz_val[7:0] == cpu_regs_pkg::BYTE_ZERO);
    end
    flags_nxt = flags_nxt | cpu_regs_pkg::FLAGS_FIXED;
  end

  // Working register, untouched by reset
  always_ff @(posedge core_clk) begin
    if (a_load) begin
      work_r <= a_nxt;
    end
  end

  // Low index byte, untouched by reset
  always_ff @(posedge core_clk) begin
    if (wr_index) begin
      index_lo_r <= writedata[7:0];
    end else if (x_load) begin
      index_lo_r <= x_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      index_hi_r <= cpu_regs_pkg::INDEX_HI_RESET;
    end else if (wr_index) begin
      index_hi_r <= writedata[15:8];
    end
  end

  // Stack pointer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stack_r <= cpu_regs_pkg::STACK_RESET;
    end else if (wr_stack) begin
      stack_r <= writedata[15:0];
    end else if (cmd_fire && (cmd.op == cpu_regs_pkg::OP_STACK_ADJ)) begin
      stack_r <= stack_r + imm_sx;
    end else if (cmd_fire && (cmd.op == cpu_regs_pkg::OP_STACK_LOW)) begin
      stack_r[7:0] <= cpu_regs_pkg::STACK_LOW_VALUE;
    end
  end

  // Program counter and reset vector load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vec_state_r   <= cpu_regs_pkg::ST_VEC_HI;
      pc_r          <= cpu_regs_pkg::PC_RESET;
      vector_addr_r <= cpu_regs_pkg::VEC_HI_ADDR;
    end else begin
      unique case (vec_state_r)
        cpu_regs_pkg::ST_VEC_HI: begin
          if (cmd_fire && (cmd.op == cpu_regs_pkg::OP_VEC_BYTE)) begin
            pc_r[15:8]    <= cmd.operand;
            vec_state_r   <= cpu_regs_pkg::ST_VEC_LO;
            vector_addr_r <= cpu_regs_pkg::VEC_LO_ADDR;
          end
        end
        cpu_regs_pkg::ST_VEC_LO: begin
          if (cmd_fire && (cmd.op == cpu_regs_pkg::OP_VEC_BYTE)) begin
            pc_r[7:0]   <= cmd.operand;
            vec_state_r <= cpu_regs_pkg::ST_RUN;
          end
        end
        cpu_regs_pkg::ST_RUN: begin
          if (wr_pc) begin
            pc_r <= writedata[15:0];
          end else if (cmd_fire && (cmd.op == cpu_regs_pkg::OP_FETCH)) begin
            pc_r <= pc_r + cpu_regs_pkg::PC_STEP;
          end
        end
        default: begin
          vec_state_r   <= cpu_regs_pkg::ST_VEC_HI;
          vector_addr_r <= cpu_regs_pkg::VEC_HI_ADDR;
        end
      endcase
    end
  end

  // Flags and signed branch conditions
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_r       <= cpu_regs_pkg::FLAGS_RESET;
      signed_cond_r <= '0;
    end else begin
      flags_r          <= flags_nxt;
      signed_cond_r.lt <= flags_nxt[cpu_regs_pkg::FLAG_N] ^ flags_nxt[cpu_regs_pkg::FLAG_V];
      signed_cond_r.ge <= ~(flags_nxt[cpu_regs_pkg::FLAG_N] ^ flags_nxt[cpu_regs_pkg::FLAG_V]);
      signed_cond_r.le <= flags_nxt[cpu_regs_pkg::FLAG_Z] |
        (flags_nxt[cpu_regs_pkg::FLAG_N] ^ flags_nxt[cpu_regs_pkg::FLAG_V]);
      signed_cond_r.gt <= ~(flags_nxt[cpu_regs_pkg::FLAG_Z] |
        (flags_nxt[cpu_regs_pkg::FLAG_N] ^ flags_nxt[cpu_regs_pkg::FLAG_V]));
    end
  end

  // Interrupt gate with one-boundary hold after unmasking; set wins over clear
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (wr_flags || (cmd_fire && (cmd.op == cpu_regs_pkg::OP_MASK_CLR))) begin
      inhibit_nxt = 1'b1;
    end else if (cmd_fire && (cmd.op == cpu_regs_pkg::OP_BOUNDARY)) begin
      inhibit_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      inhibit_r     <= 1'b0;
      irq_allowed_r <= 1'b0;
    end else begin
      inhibit_r     <= inhibit_nxt;
      irq_allowed_r <= ~flags_nxt[cpu_regs_pkg::FLAG_I] & ~inhibit_nxt & fetch_ok;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_reset_values: assert property (
      $fell(reset) |-> stack_r == cpu_regs_pkg::STACK_RESET
      && index_hi_r == cpu_regs_pkg::INDEX_HI_RESET
      && vector_addr_r == cpu_regs_pkg::VEC_HI_ADDR)
    else $error("reset values wrong");
  a_flags_fixed: assert property (
      (flags_r & cpu_regs_pkg::FLAGS_FIXED) == cpu_regs_pkg::FLAGS_FIXED)
    else $error("fixed flag bits not one");
  a_pc_advance: assert property (
      fetch_ok && cmd_fire && cmd.op == cpu_regs_pkg::OP_FETCH && !wr_pc
      |=> pc_r == $past(pc_r) + cpu_regs_pkg::PC_STEP)
    else $error("program counter did not advance");
  a_stack_adjust: assert property (
      cmd_fire && cmd.op == cpu_regs_pkg::OP_STACK_ADJ
      |=> stack_r == $past(stack_r) + $past(imm_sx))
    else $error("stack adjust wrong");
  a_stack_low: assert property (
      cmd_fire && cmd.op == cpu_regs_pkg::OP_STACK_LOW
      |=> stack_r[15:8] == $past(stack_r[15:8])
      && stack_r[7:0] == cpu_regs_pkg::STACK_LOW_VALUE)
    else $error("stack reload touched high byte");
  a_vector_order: assert property (
      vec_state_r == cpu_regs_pkg::ST_VEC_LO && cmd_fire
      && cmd.op == cpu_regs_pkg::OP_VEC_BYTE |=> pc_r[15:8] == $past(pc_r[15:8])
      && pc_r[7:0] == $past(cmd.operand))
    else $error("vector low byte misplaced");
  a_unmask_hold: assert property (
      cmd_fire && cmd.op == cpu_regs_pkg::OP_MASK_CLR |=> !irq_allowed_r && inhibit_r)
    else $error("interrupt allowed right after unmask");
  a_mask_set: assert property (
      cmd_fire && cmd.op == cpu_regs_pkg::OP_MASK_SET
      |=> flags_r[cpu_regs_pkg::FLAG_I] && !irq_allowed_r)
    else $error("mask not set on entry");
  a_zero_load: assert property (
      wr_work |=> work_r == $past(writedata[7:0])
      && flags_r[cpu_regs_pkg::FLAG_Z] == (work_r == cpu_regs_pkg::BYTE_ZERO)
      && flags_r[cpu_regs_pkg::FLAG_N] == work_r[7])
    else $error("load flags wrong");
  a_bus_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

  c_vector_done: cover property (vec_state_r == cpu_regs_pkg::ST_VEC_LO ##[1:50]
      vec_state_r == cpu_regs_pkg::ST_RUN);
  c_unmask_release: cover property (inhibit_r ##[1:50] irq_allowed_r);
  c_stack_adjust: cover property (cmd_fire && cmd.op == cpu_regs_pkg::OP_STACK_ADJ
      && cmd.operand[7]);
  c_bcd_adjust: cover property (cmd_fire && cmd.op == cpu_regs_pkg::OP_BCD_ADJ && hi_fix);

endmodule : cpu_regs
`default_nettype wire

// File: sim/cpu_decoder_model.sv
// Purpose: Decoder-side master on the core register port
// Assumes: Avalon-MM, one request at a time
// Notes:   Released address and data lines show the inverse of their last value; read and write drop to 0
`default_nettype none
module cpu_decoder_model (
  input  wire logic        core_clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output var  logic [7:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {address, read, write, writedata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    {address, read, write, writedata} <= {a, !w, w, d};
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    {address, read, write, writedata} <= {~a, 1'b0, 1'b0, ~d};
  endtask : xfer
endmodule : cpu_decoder_model
`default_nettype wire

// File: sim/cpu_programmer_register_set_tb.sv
// Purpose: Self-checking bench for the CPU programmer register set
// Assumes: Offsets and op codes as in the package map
// Notes:   Expected values come from the bench's own register model
`default_nettype none
module cpu_programmer_register_set_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       core_clk, reset, read, write, waitrequest, irq_allowed_r, cy;
  logic [7:0]                 address, work_r, index_hi_r, index_lo_r, flags_r, a, h, x, f, d;
  logic [15:0]                stack_r, pc_r, vector_addr_r, s, p;
  logic [31:0]                writedata, readdata, q;
  int                         fails, n_checks, cyc, c, k;
  cpu_regs_pkg::signed_cond_t signed_cond_r;
  cpu_regs i_cpu_regs (.core_clk, .reset, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .work_r, .index_hi_r, .index_lo_r, .stack_r, .pc_r, .flags_r,
    .irq_allowed_r, .signed_cond_r, .vector_addr_r);
  cpu_decoder_model i_cpu_decoder_model (.core_clk, .waitrequest, .readdata, .address,
    .read, .write, .writedata);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) fails++;
    if (cyc == 5000) results();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e) fails++;
    if (seen !== e) $display("[ERR] %0t seen %h expected %h", $time, seen, e);
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    i_cpu_decoder_model.xfer(1'b1, ad, wd, q);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk = '1);
    i_cpu_decoder_model.xfer(1'b0, ad, 32'h0, q);
    check(q & mk, e & mk);
  endtask : rd
  task automatic op(input logic [4:0] o, input logic [7:0] v, input logic [2:0] vhc);
    wr(8'h14, {3'h0, o, 5'h0, vhc, 8'h0, v});
  endtask : op
  task automatic results;
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    {reset, f, k} = {1'b1, 8'h68, $urandom(32'h4a29)};
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check({index_hi_r, stack_r, flags_r}, 32'h0000FF68);
    check({pc_r, vector_addr_r}, 32'h0000FFFE);
    p = 16'($urandom);
    op(5'h15, p[15:8], 3'h0);
    rd(8'h18, 32'h08);
    check(32'(vector_addr_r), 32'hFFFF);
    op(5'h15, p[7:0], 3'h0);
    rd(8'h0C, 32'(p));
    wr(8'h0C, 32'hFFFF);
    op(5'h01, 8'h0, 3'h0);
    rd(8'h0C, 32'h0);
    for (k = 0; k < 3; k++) begin
      a = k == 2 ? 8'($urandom) : {k[0], 7'h0};
      wr(8'h00, 32'(a));
      f = {1'b0, f[6:3], a[7], a == 8'h0, f[0]};
      rd(8'h10, 32'(f));
    end
    {h, x} = 16'($urandom);
    wr(8'h04, 32'({h, x}));
    for (c = 4; c < 13; c++) begin
      op(5'(c), 8'h0, 3'h0);
      case (c)
        4: {x, cy} = {8'h0, f[0]};
        5: {x, cy} = {x + 8'h1, f[0]};
        6: {x, cy} = {x - 8'h1, f[0]};
        7: {x, cy} = {~x, 1'b1};
        8: {x, cy} = {-x, x != 8'h0};
        9: {cy, x} = {x, 1'b0};
        10: {x, cy} = {1'b0, x};
        11: {cy, x} = {x, f[0]};
        default: {x, cy} = {f[0], x};
      endcase
      f = {(c != 7) & (x[7] ^ cy), f[6:3], x[7], x == 8'h0, cy};
      rd(8'h10, 32'(f), c < 7 ? 32'h6 : c == 8 ? 32'h7 : 32'h87);
      rd(8'h04, 32'({h, x}));
    end
    op(5'h0D, 8'h0, 3'h0);
    rd(8'h04, 32'({h, a}));
    op(5'h07, 8'h0, 3'h0);
    op(5'h0E, 8'h0, 3'h0);
    {x, a} = {~a, ~a};
    rd(8'h00, 32'(a));
    rd(8'h10, {29'h0, a[7], a == 8'h0, 1'b0}, 32'h6);
    s = 16'($urandom);
    wr(8'h08, 32'(s));
    for (k = 0; k < 3; k++) begin
      d = k == 2 ? 8'($urandom) : 8'h7F + 8'(k);
      op(5'h02, d, 3'h0);
      s = s + {{8{d[7]}}, d};
      rd(8'h08, 32'(s));
    end
    op(5'h03, 8'h0, 3'h0);
    rd(8'h08, {16'h0, s[15:8], 8'hFF});
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h60);
    rd(8'h18, 32'h12);
    op(5'h14, 8'h0, 3'h0);
    rd(8'h18, 32'h11);
    check(32'(irq_allowed_r), 32'h1);
    op(5'h13, 8'h0, 3'h0);
    rd(8'h10, 32'h68);
    rd(8'h18, 32'h10);
    op(5'h12, 8'h0, 3'h0);
    rd(8'h18, 32'h12);
    for (k = 0; k < 6; k++) begin
      {d, c} = {8'($urandom), $urandom};
      op(k[0] ? 5'h10 : 5'h0F, d, 3'(c));
      {f, cy} = {c[2], 2'b11, k[0] ? f[4] : c[1], 1'b0, d[7], d == 8'h0, c[0], d[7] ^ c[2]};
      rd(8'h10, 32'(f));
      check(32'(signed_cond_r), {28'h0, ~(f[1] | cy), ~cy, f[1] | cy, cy});
      op(5'h11, 8'h0, 3'h0);
      a = d + (f[4] || d[3:0] > 4'h9 ? 8'h06 : 8'h0) + (f[0] || d > 8'h99 ? 8'h60 : 8'h0);
      rd(8'h00, 32'(a));
    end
    rd(8'h1C, 32'h0);
    rd(8'h14, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check({work_r, index_lo_r, stack_r}, {a, x, 16'h00FF});
    results();
  end
endmodule : cpu_programmer_register_set_tb
`default_nettype wire
